// [logic/i2c_byte_master.sv]
// Two-wire bus master executing start, stop, byte write and byte read
`timescale 1ns/1ps
module i2c_byte_master (
    input logic core_clk,
    input logic reset_n,
    i2c_link_if.host link,
    input logic [1:0] addr,
    input logic [7:0] wr_data,
    input logic wr_en,
    input logic rd_en,
    output logic [7:0] rd_data
);
    localparam logic [6:0] QUARTER_CYCLES = i2c_link_pkg::QUARTER_CYCLES;
    localparam logic [3:0] BYTE_BITS = i2c_link_pkg::BYTE_BITS;
    localparam logic [1:0] HOST_CMD = i2c_link_pkg::HOST_CMD;
    localparam logic [1:0] HOST_TX = i2c_link_pkg::HOST_TX;
    localparam logic [1:0] HOST_RX = i2c_link_pkg::HOST_RX;
    localparam logic [1:0] HOST_STATUS = i2c_link_pkg::HOST_STATUS;
    localparam int CMD_NACK_BIT = i2c_link_pkg::CMD_NACK_BIT;
    localparam logic [1:0] OP_START = i2c_link_pkg::OP_START;
    localparam logic [1:0] OP_STOP = i2c_link_pkg::OP_STOP;
    localparam logic [1:0] OP_WRITE = i2c_link_pkg::OP_WRITE;
    localparam logic [1:0] OP_READ = i2c_link_pkg::OP_READ;
    typedef enum {st_idle, st_run} state_t;

    state_t state;
    state_t next_state;
    logic [1:0] op;
    logic [1:0] next_op;
    logic send_nack;
    logic next_send_nack;
    logic [7:0] tx;
    logic [7:0] next_tx;
    logic [7:0] rx;
    logic [7:0] next_rx;
    logic nack;
    logic next_nack;
    logic [6:0] qcnt;
    logic [6:0] next_qcnt;
    logic [1:0] quarter;
    logic [1:0] next_quarter;
    logic [3:0] bit_n;
    logic [3:0] next_bit_n;
    logic scl_oe;
    logic next_scl_oe;
    logic sda_oe;
    logic next_sda_oe;
    logic [7:0] next_rd_data;
    logic [2:0] sda_sync;
    logic sda_f;
    logic next_sda_f;
    logic tick;
    logic data_bit;

    assign tick = (qcnt == QUARTER_CYCLES - 7'h01);
    assign data_bit = (bit_n < BYTE_BITS);

    always_comb begin
        next_sda_f = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
        next_state = state;
        next_op = op;
        next_send_nack = send_nack;
        next_tx = tx;
        next_rx = rx;
        next_nack = nack;
        next_qcnt = qcnt;
        next_quarter = quarter;
        next_bit_n = bit_n;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        next_rd_data = rd_data;
        if (rd_en) begin
            unique case (addr)
                HOST_CMD: next_rd_data = {5'h00, send_nack, op};
                HOST_TX: next_rd_data = tx;
                HOST_RX: next_rd_data = rx;
                HOST_STATUS: next_rd_data = {6'h00, nack, state == st_run};
            endcase
        end
        // Orders arriving mid-operation are dropped, not queued
        if (wr_en && state == st_idle) begin
            if (addr == HOST_CMD) begin
                next_op = wr_data[1:0];
                next_send_nack = wr_data[CMD_NACK_BIT];
                next_state = st_run;
                next_qcnt = 7'h00;
                next_quarter = 2'h0;
                next_bit_n = 4'h0;
            end else if (addr == HOST_TX) begin
                next_tx = wr_data;
            end
        end
        if (state == st_run) begin
            next_qcnt = tick ? 7'h00 : qcnt + 7'h01;
            if (tick) begin
                next_quarter = quarter + 2'h1;
                unique case (quarter)
                    // data bits change only with clock low; start and stop move data in quarter 2 with clock high
                    2'h0: begin
                        unique case (op)
                            OP_START: next_sda_oe = 1'b0;
                            OP_STOP: next_sda_oe = 1'b1;
                            // msb first, low pulls for zero
                            OP_WRITE: next_sda_oe = data_bit & ~tx[7];
                            OP_READ: next_sda_oe = ~data_bit & ~send_nack;
                        endcase
                    end
                    2'h1: next_scl_oe = 1'b0;
                    2'h2: begin
                        unique case (op)
                            OP_START: next_sda_oe = 1'b1;
                            OP_STOP: next_sda_oe = 1'b0;
                            OP_WRITE: begin
                                if (!data_bit) begin
                                    next_nack = sda_f;
                                end
                            end
                            OP_READ: begin
                                if (data_bit) begin
                                    next_rx = {rx[6:0], sda_f};
                                end
                            end
                        endcase
                    end
                    2'h3: begin
                        if (op != OP_STOP) begin
                            next_scl_oe = 1'b1;
                        end
                        if (op == OP_START || op == OP_STOP ||
                            !data_bit) begin
                            next_state = st_idle;
                        end else begin
                            next_bit_n = bit_n + 4'h1;
                            next_tx = {tx[6:0], 1'b0};
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_sync <= 3'h7;
            sda_f <= 1'b1;
            state <= st_idle;
            op <= OP_START;
            send_nack <= 1'b0;
            tx <= 8'h00;
            rx <= 8'h00;
            nack <= 1'b0;
            qcnt <= 7'h00;
            quarter <= 2'h0;
            bit_n <= 4'h0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            sda_sync <= {sda_sync[1:0], link.sda};
            sda_f <= next_sda_f;
            state <= next_state;
            op <= next_op;
            send_nack <= next_send_nack;
            tx <= next_tx;
            rx <= next_rx;
            nack <= next_nack;
            qcnt <= next_qcnt;
            quarter <= next_quarter;
            bit_n <= next_bit_n;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            rd_data <= next_rd_data;
        end
    end

    assign link.host_scl_oe = scl_oe;
    assign link.host_sda_oe = sda_oe;
endmodule // i2c_byte_master

// [logic/i2c_link_if.sv]
// Open-drain two-wire link joining the bus master and the register slave
`timescale 1ns/1ps
interface i2c_link_if;
    logic host_scl_oe;
    logic host_sda_oe;
    logic dev_sda_oe;
    logic scl;
    logic sda;
    assign scl = ~host_scl_oe;
    assign sda = ~(host_sda_oe | dev_sda_oe);
    modport host (
        output host_scl_oe,
        output host_sda_oe,
        input scl,
        input sda
    );
    modport device (
        output dev_sda_oe,
        input scl,
        input sda
    );
endinterface

// [logic/i2c_link_pkg.sv]
// Shared constants for the two-wire register link and its two ends
package i2c_link_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h18;
    localparam logic [7:0] GEN_CALL_BYTE = 8'h00;
    localparam logic [6:0] REG_PAGE_SELECT = 7'h00;
    localparam logic [6:0] REG_SOFT_RESET = 7'h01;
    localparam logic [6:0] REG_RESERVED_TWO = 7'h02;
    localparam logic [6:0] REG_GEN_CALL_CTRL = 7'h22;
    localparam int GEN_CALL_EN_BIT = 5;
    localparam int SOFT_RESET_BIT = 0;
    localparam logic [7:0] PAGE_HOME = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [6:0] BANK_DEPTH = 7'h40;
    localparam int BANK_AW = 6;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // Host register port
    localparam logic [1:0] HOST_CMD = 2'h0;
    localparam logic [1:0] HOST_TX = 2'h1;
    localparam logic [1:0] HOST_RX = 2'h2;
    localparam logic [1:0] HOST_STATUS = 2'h3;
    localparam int CMD_NACK_BIT = 2;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_NACK_BIT = 1;
    localparam logic [1:0] OP_START = 2'h0;
    localparam logic [1:0] OP_STOP = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam logic [1:0] OP_READ = 2'h3;
    // Serial clock timing: four quarters per bit
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_QUARTER_NS = 625;
    localparam logic [6:0] QUARTER_CYCLES =
        7'(SCL_QUARTER_NS / CLK_PERIOD_NS);
endpackage

// [logic/i2c_paged_register_slave.sv]
// Two-wire slave giving access to a paged bank of 8-bit registers
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module i2c_paged_register_slave (
    input logic core_clk,
    input logic reset_n,
    i2c_link_if.device link,
    output logic [7:0] page_sel,
    output logic gc_enable,
    output logic soft_reset_pulse,
    output logic addressed
);
    localparam logic [6:0] SLAVE_ADDR = i2c_link_pkg::SLAVE_ADDR;
    localparam logic [6:0] REG_PAGE_SELECT = i2c_link_pkg::REG_PAGE_SELECT;
    localparam logic [6:0] REG_SOFT_RESET = i2c_link_pkg::REG_SOFT_RESET;
    localparam logic [6:0] REG_RESERVED_TWO = i2c_link_pkg::REG_RESERVED_TWO;
    localparam logic [6:0] REG_GEN_CALL_CTRL = i2c_link_pkg::REG_GEN_CALL_CTRL;
    localparam int GEN_CALL_EN_BIT = i2c_link_pkg::GEN_CALL_EN_BIT;
    localparam int SOFT_RESET_BIT = i2c_link_pkg::SOFT_RESET_BIT;
    localparam logic [7:0] PAGE_HOME = i2c_link_pkg::PAGE_HOME;
    localparam logic [7:0] REG_RESET = i2c_link_pkg::REG_RESET;
    localparam logic [6:0] BANK_DEPTH = i2c_link_pkg::BANK_DEPTH;
    localparam int BANK_AW = i2c_link_pkg::BANK_AW;
    localparam logic [3:0] BYTE_BITS = i2c_link_pkg::BYTE_BITS;
    typedef enum {st_idle, st_rx, st_ack, st_tx, st_mack, st_ignore} state_t;
    typedef enum {kind_addr, kind_ptr, kind_data} kind_t;

    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_f;
    logic sda_f;
    logic scl_d;
    logic sda_d;
    logic next_scl_f;
    logic next_sda_f;
    state_t state;
    state_t next_state;
    kind_t kind;
    kind_t next_kind;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [6:0] ptr;
    logic [6:0] next_ptr;
    logic rw;
    logic next_rw;
    logic sda_oe;
    logic next_sda_oe;
    logic [7:0] page;
    logic [7:0] next_page;
    logic [7:0] bank [0:BANK_DEPTH-1];
    logic [7:0] next_bank [0:BANK_DEPTH-1];
    logic next_soft_pulse;
    logic next_addressed;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic gc_hit;
    logic [7:0] rd_value;

    function automatic logic [7:0] read_reg(input logic [7:0] pg,
                                            input logic [6:0] idx,
                                            input logic [7:0] entry);
        logic [7:0] value;
        value = REG_RESET;
        if (idx == REG_PAGE_SELECT) begin
            value = pg;
        end else if (pg == PAGE_HOME && idx != REG_RESERVED_TWO &&
                     idx < BANK_DEPTH) begin
            value = entry;
        end
        return value;
    endfunction

    // Link pins are foreign to core_clk; accept a level once stages agree
    always_comb begin
        next_scl_f = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_f;
        next_sda_f = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[1:0], link.scl};
            sda_sync <= {sda_sync[1:0], link.sda};
            scl_f <= next_scl_f;
            sda_f <= next_sda_f;
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    assign scl_rise = scl_f & ~scl_d;
    assign scl_fall = ~scl_f & scl_d;
    assign start_cond = scl_f & scl_d & sda_d & ~sda_f;
    assign stop_cond = scl_f & scl_d & ~sda_d & sda_f;
    assign gc_hit = (shreg == i2c_link_pkg::GEN_CALL_BYTE) &&
                    bank[REG_GEN_CALL_CTRL[BANK_AW-1:0]][GEN_CALL_EN_BIT];
    assign rd_value = read_reg(page, ptr, bank[ptr[BANK_AW-1:0]]);

    always_comb begin
        next_state = state;
        next_kind = kind;
        next_cnt = cnt;
        next_shreg = shreg;
        next_ptr = ptr;
        next_rw = rw;
        next_sda_oe = sda_oe;
        next_page = page;
        next_bank = bank;
        next_soft_pulse = 1'b0;
        next_addressed = addressed;
        // start restarts decoding in any state
        if (start_cond) begin
            next_state = st_rx;
            next_kind = kind_addr;
            next_cnt = 4'h0;
            next_sda_oe = 1'b0;
            next_addressed = 1'b0;
        end else if (stop_cond) begin
            next_state = st_idle;
            next_sda_oe = 1'b0;
            next_addressed = 1'b0;
        end else begin
            unique case (state)
                st_idle, st_ignore: begin
                end
                st_rx: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_f};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == BYTE_BITS) begin
                        next_state = st_ack;
                        next_sda_oe = 1'b1;
                        unique case (kind)
                            kind_addr: begin
                                if (shreg[7:1] == SLAVE_ADDR || gc_hit) begin
                                    next_rw = shreg[0] & ~gc_hit;
                                    next_kind = kind_ptr;
                                    next_addressed = 1'b1;
                                end else begin
                                    next_state = st_ignore;
                                    next_sda_oe = 1'b0;
                                end
                            end
                            kind_ptr: begin
                                next_ptr = shreg[6:0];
                                next_kind = kind_data;
                            end
                            kind_data: begin
                                next_ptr = ptr + 7'h01;
                                if (ptr == REG_PAGE_SELECT) begin
                                    next_page = shreg;
                                end else if (page == PAGE_HOME &&
                                             ptr == REG_SOFT_RESET) begin
                                    if (shreg[SOFT_RESET_BIT]) begin
                                        next_bank = '{default: REG_RESET};
                                        next_page = PAGE_HOME;
                                        next_soft_pulse = 1'b1;
                                    end
                                end else if (page == PAGE_HOME &&
                                             ptr != REG_RESERVED_TWO &&
                                             ptr < BANK_DEPTH) begin
                                    next_bank[ptr[BANK_AW-1:0]] = shreg;
                                end
                            end
                        endcase
                    end
                end
                st_ack: begin
                    if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (rw) begin
                            next_state = st_tx;
                            next_shreg = rd_value;
                            next_sda_oe = ~rd_value[7];
                        end else begin
                            next_state = st_rx;
                            next_sda_oe = 1'b0;
                        end
                    end
                end
                st_tx: begin
                    if (scl_fall) begin
                        if (cnt == BYTE_BITS - 4'h1) begin
                            next_state = st_mack;
                            next_cnt = 4'h0;
                            next_sda_oe = 1'b0;
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_cnt = cnt + 4'h1;
                            next_sda_oe = ~shreg[6];
                        end
                    end
                end
                st_mack: begin
                    if (scl_rise) begin
                        if (!sda_f) begin
                            next_ptr = ptr + 7'h01;
                            next_cnt = BYTE_BITS;
                        end else begin
                            next_state = st_ignore;
                        end
                    end else if (scl_fall && cnt == BYTE_BITS) begin
                        next_state = st_tx;
                        next_cnt = 4'h0;
                        next_shreg = rd_value;
                        next_sda_oe = ~rd_value[7];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= st_idle;
            kind <= kind_addr;
            cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 7'h00;
            rw <= 1'b0;
            sda_oe <= 1'b0;
            page <= PAGE_HOME;
            bank <= '{default: REG_RESET};
            soft_reset_pulse <= 1'b0;
            addressed <= 1'b0;
        end else begin
            state <= next_state;
            kind <= next_kind;
            cnt <= next_cnt;
            shreg <= next_shreg;
            ptr <= next_ptr;
            rw <= next_rw;
            sda_oe <= next_sda_oe;
            page <= next_page;
            bank <= next_bank;
            soft_reset_pulse <= next_soft_pulse;
            addressed <= next_addressed;
        end
    end

    // data pin only; clock is never driven
    assign link.dev_sda_oe = sda_oe;
    assign page_sel = page;
    assign gc_enable = bank[REG_GEN_CALL_CTRL[BANK_AW-1:0]][GEN_CALL_EN_BIT];
endmodule // i2c_paged_register_slave

// [verif/i2c_link_assertions.sv]
// Wire-level checker for the two-wire link between master and slave
`timescale 1ns/1ps
module i2c_link_assertions (
    input logic core_clk,
    input logic reset_n,
    input logic host_scl_oe,
    input logic host_sda_oe,
    input logic dev_sda_oe,
    input logic scl,
    input logic sda
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_wired;
        sda == !(host_sda_oe || dev_sda_oe);
    endproperty
    a_wired: assert property (p_wired)
        else $error("data line not the wired level of both pulls");

    property p_scl_host;
        scl == !host_scl_oe;
    endproperty
    a_scl_host: assert property (p_scl_host)
        else $error("clock line not set by the master alone");

    property p_dev_still;
        scl && $past(scl) |-> $stable(dev_sda_oe);
    endproperty
    a_dev_still: assert property (p_dev_still)
        else $error("slave moved data while clock high");

    property p_scl_high;
        $rose(scl) |-> scl [*8];
    endproperty
    a_scl_high: assert property (p_scl_high)
        else $error("clock high phase too short");

    property p_scl_low;
        $fell(scl) |-> (!scl) [*8];
    endproperty
    a_scl_low: assert property (p_scl_low)
        else $error("clock low phase too short");

    property p_start;
        scl && $fell(sda) |-> ##[1:200] $fell(scl);
    endproperty
    a_start: assert property (p_start)
        else $error("no clock after start condition");

    property p_stop;
        scl && $rose(sda) |-> ##1 (scl && sda) [*8];
    endproperty
    a_stop: assert property (p_stop)
        else $error("bus not idle after stop condition");

    property p_ack_hold;
        $rose(dev_sda_oe) |-> dev_sda_oe [*8];
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("slave pull released too early");
endmodule // i2c_link_assertions

// [verif/i2c_paged_register_slave_bench.sv]
// Bench joining the register slave and the bus master over the link
`timescale 1ns/1ps
module i2c_paged_register_slave_bench;
    localparam logic [7:0] WR = {i2c_link_pkg::SLAVE_ADDR, 1'b0};
    localparam logic [7:0] RD = {i2c_link_pkg::SLAVE_ADDR, 1'b1};
    localparam logic [7:0] GC_PTR = {1'b0, i2c_link_pkg::REG_GEN_CALL_CTRL};
    localparam logic [7:0] GC_ON = 8'(1 << i2c_link_pkg::GEN_CALL_EN_BIT);
    localparam int LIMIT = 90000;
    logic core_clk;
    logic reset_n;
    logic [1:0] addr;
    logic [7:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [7:0] rd_data;
    logic [7:0] page_sel;
    logic gc_enable;
    logic soft_reset_pulse;
    logic addressed;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    int n_pulse = 0;
    i2c_link_if link();
    i2c_paged_register_slave i2c_paged_register_slave_i (
        .core_clk(core_clk), .reset_n(reset_n), .link(link.device),
        .page_sel(page_sel), .gc_enable(gc_enable),
        .soft_reset_pulse(soft_reset_pulse), .addressed(addressed));
    i2c_byte_master i2c_byte_master_i (
        .core_clk(core_clk), .reset_n(reset_n), .link(link.host),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data));
    i2c_link_assertions i2c_link_assertions_i (
        .core_clk(core_clk), .reset_n(reset_n),
        .host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe),
        .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (soft_reset_pulse === 1'b1) begin
            n_pulse <= n_pulse + 1;
        end
        // Hang guard
        if (cycles == LIMIT) begin
            n_fail++;
            results();
        end
    end
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask
    // Command, then poll busy; a stuck busy is counted after 3000 polls
    task automatic op(input logic [7:0] cmd);
        logic [7:0] s;
        int n;
        reg_wr(i2c_link_pkg::HOST_CMD, cmd);
        s = 8'h01;
        n = 0;
        while (s[0] !== 1'b0 && n < 3000) begin
            reg_rd(i2c_link_pkg::HOST_STATUS, s);
            n++;
        end
        // Busy never cleared: count it, later ops fall to the hang guard
        if (s[0] !== 1'b0) begin
            n_fail++;
            $display("mismatch at %0t: operation never finished", $time);
        end
    endtask
    task automatic start;
        op({6'h00, i2c_link_pkg::OP_START});
    endtask
    task automatic stop;
        op({6'h00, i2c_link_pkg::OP_STOP});
    endtask
    task automatic wb(input logic [7:0] d, input logic nack);
        logic [7:0] s;
        reg_wr(i2c_link_pkg::HOST_TX, d);
        op({6'h00, i2c_link_pkg::OP_WRITE});
        reg_rd(i2c_link_pkg::HOST_STATUS, s);
        chk({7'h00, s[1]}, {7'h00, nack});
    endtask
    task automatic rb(input logic nack, input logic [7:0] exp);
        logic [7:0] v;
        op({5'h00, nack, i2c_link_pkg::OP_READ});
        reg_rd(i2c_link_pkg::HOST_RX, v);
        chk(v, exp);
    endtask
    task automatic gcall_off;
        chk(page_sel, 8'h00);
        start();
        wb(i2c_link_pkg::GEN_CALL_BYTE, 1'b1);
        stop();
    endtask
    task automatic write_burst;
        start();
        wb(WR, 1'b0);
        chk({7'h00, addressed}, 8'h01);
        wb(GC_PTR, 1'b0);
        wb(GC_ON, 1'b0);
        wb(8'hA5, 1'b0);
        stop();
        chk({7'h00, gc_enable}, 8'h01);
        chk({7'h00, addressed}, 8'h00);
    endtask
    task automatic read_burst;
        start();
        wb(WR, 1'b0);
        wb(GC_PTR, 1'b0);
        start();
        wb(RD, 1'b0);
        rb(1'b0, GC_ON);
        rb(1'b1, 8'hA5);
        stop();
    endtask
    task automatic foreign_addr;
        start();
        wb({i2c_link_pkg::SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1);
        chk({7'h00, addressed}, 8'h00);
        stop();
        start();
        wb(i2c_link_pkg::GEN_CALL_BYTE, 1'b0);
        stop();
    endtask
    // A page away from home (0D), then back home
    task automatic page_switch(input logic [7:0] pg);
        start();
        wb(WR, 1'b0);
        wb(8'h00, 1'b0);
        wb(pg, 1'b0);
        stop();
        chk(page_sel, pg);
    endtask
    task automatic soft_reset;
        start();
        wb(WR, 1'b0);
        wb({1'b0, i2c_link_pkg::REG_SOFT_RESET}, 1'b0);
        wb(8'h01, 1'b0);
        stop();
        chk({7'h00, gc_enable}, 8'h00);
        chk(8'(n_pulse), 8'h01);
        start();
        wb(WR, 1'b0);
        wb({1'b0, i2c_link_pkg::REG_PAGE_SELECT}, 1'b0);
        start();
        wb(RD, 1'b0);
        rb(1'b0, i2c_link_pkg::PAGE_HOME);
        rb(1'b1, 8'h00);
        stop();
    endtask
    initial begin
        reset_n = 1'b0;
        addr = 2'h0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        gcall_off();
        write_burst();
        read_burst();
        foreign_addr();
        page_switch(8'h0D);
        page_switch(8'h00);
        soft_reset();
        results();
    end
endmodule // i2c_paged_register_slave_bench
